// File: hdl/fdt_consts.svh
// Purpose: Constants of the discovery table reader, both ends.
// Assumes: Serial link in clock mode 0, most significant bit first.
// Notes:   Table bytes are packed with the lowest address in the low bits.
`ifndef FDT_CONSTS_SVH
`define FDT_CONSTS_SVH

// Command code of the discovery read.
`define FDT_CMD        8'hA5
// Command length in link clocks.
`define FDT_CMD_BITS   5'h08
// Address length in link clocks, always three bytes.
`define FDT_ADDR_BITS  5'h18
// Dummy clocks between address and first data bit.
`define FDT_DUMMY_BITS 5'h08
// Link clocks before data: command, address and dummy.
`define FDT_HEAD_BITS  20'h00028
// Width of a table address; the table spans 2048 bytes.
`define FDT_TBL_AW     11
// Value of every unpopulated table byte.
`define FDT_FILL       8'hFF
// Base of the header block and of the parameter block, in 16-byte rows.
`define FDT_HDR_ROW    7'h00
`define FDT_BPT_ROW    7'h03
// Header, bytes 00h..0Fh.
`define FDT_HDR_SIG    32'h50444653
`define FDT_HDR_REV    32'hFF000100
`define FDT_HDR_PH0    64'hFF00003009010000
// Parameter block, bytes 30h..3Fh.
`define FDT_BPT_ERASE  16'h20E5
`define FDT_BPT_SIZE   48'h1FFFFFFFFFFB
`define FDT_BPT_QIO    16'hEB29
`define FDT_BPT_QO     16'h6B27
`define FDT_BPT_DO     16'h3B27
`define FDT_BPT_DIO    16'hBB27
// Host link clock half period in system clocks.
`define FDT_HALF_DEF   8

`endif

// File: hdl/fdt_pkg.sv
// Purpose: Types shared by both ends of the discovery table link.
// Assumes: Nothing beyond the constants header.
// Notes:   States carry no codes; the tools pick them.
package fdt_pkg;

   // Device end states.
   typedef enum logic [2:0] {
      FDT_D_CMD, FDT_D_ADDR, FDT_D_DUMMY, FDT_D_DATA, FDT_D_SKIP
   } fdt_dev_state_e;

   // Host end states.
   typedef enum logic [1:0] {
      FDT_H_IDLE, FDT_H_SETUP, FDT_H_XFER, FDT_H_HOLD
   } fdt_host_state_e;

endpackage

// File: hdl/fdt_if.sv
// Purpose: Serial link between the host end and the table device end.
// Assumes: One select, one clock, one input line and one output line.
// Notes:   A released output line shows the inverse of the device bit.
`timescale 1ns/10ps

interface fdt_if;
   logic sck;             // Link clock, made by the host.
   logic cs_n;            // Select, active low.
   logic serial_in_line;  // Host to device data.
   logic sout;            // Device output value.
   logic sout_oe_n;       // Device output enable, low drives.
   wire  serial_out_line; // Resolved device to host line.

   // A released line shows the inverse of the last bit, so a host that
   // samples outside the driven window reads a wrong bit, not a held one.
   assign serial_out_line = sout_oe_n ? ~sout : sout;

   // Device end.
   modport dev (input sck, input cs_n, input serial_in_line,
                output sout, output sout_oe_n);
   // Host end.
   modport host (output sck, output cs_n, output serial_in_line,
                 input serial_out_line);
endinterface

// File: hdl/fdt_dev.sv
// Purpose: Device end that serves the flash discovery table over the link.
// Assumes: Link clock mode 0; the link pins are asynchronous to MCLK.
// Notes:   Link clock edges are found by sampling; MCLK must run at least
//          eight times faster than the link clock.
`timescale 1ns/10ps
`include "fdt_consts.svh"

module fdt_dev
   import fdt_pkg::*;
#(
   parameter logic [7:0] CMD_CODE = `FDT_CMD // Discovery read command.
)(
   input  wire logic MCLK,     // System clock.
   input  wire logic NRST,     // Asynchronous reset, active low.
   fdt_if.dev        LINK,     // Serial link to the host.
   output logic      SELECTED, // Select seen low after synchronising.
   output logic      STREAMING // Table bytes are being sent.
);

   ////////////////////////////////////////////////////////////////////////
   // Table contents.
   ////////////////////////////////////////////////////////////////////////

   // Returns the table byte at a table address.
   function automatic logic [7:0] table_byte(
      input logic [`FDT_TBL_AW-1:0] a);
      logic [127:0] hdr;
      logic [127:0] bpt;
      logic [6:0]   lane;
      hdr = {`FDT_HDR_PH0,
             `FDT_HDR_REV,
             `FDT_HDR_SIG};
      bpt = {`FDT_BPT_DIO,
             `FDT_BPT_DO,
             `FDT_BPT_QO,
             `FDT_BPT_QIO,
             `FDT_BPT_SIZE,
             `FDT_BPT_ERASE};
      lane = {a[3:0], 3'h0};
      if (a[10:4] == `FDT_HDR_ROW) begin
         table_byte = hdr[lane +: 8];
      end else if (a[10:4] == `FDT_BPT_ROW) begin
         table_byte = bpt[lane +: 8];
      end else begin
         table_byte = `FDT_FILL;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   ////////////////////////////////////////////////////////////////////////

   logic sck_s1;   // Link clock, first stage.
   logic sck_s2;   // Link clock, second stage.
   logic sck_s3;   // Link clock, previous value for edge finding.
   logic cs_s1;    // Select, first stage.
   logic cs_s2;    // Select, second stage.
   logic sin_s1;   // Input line, first stage.
   logic sin_s2;   // Input line, second stage.

   // Every link pin passes two flip-flops before any logic reads it.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_s3 <= 1'b0;
         cs_s1  <= 1'b1;
         cs_s2  <= 1'b1;
         sin_s1 <= 1'b0;
         sin_s2 <= 1'b0;
      end else begin
         sck_s1 <= LINK.sck;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         cs_s1  <= LINK.cs_n;
         cs_s2  <= cs_s1;
         sin_s1 <= LINK.serial_in_line;
         sin_s2 <= sin_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decoding.
   ////////////////////////////////////////////////////////////////////////

   fdt_dev_state_e         state;      // Phase of the current frame.
   fdt_dev_state_e         next_state; // Phase after this rising edge.
   logic [4:0]             cnt;        // Clocks seen in the current phase.
   logic [23:0]            in_sh;      // Bits shifted in so far.
   logic [`FDT_TBL_AW-1:0] addr;       // Next table address to send.
   logic [2:0]             bit_cnt;    // Bit of the byte on the line.
   logic [6:0]             out_sh;     // Remaining bits of the byte.

   wire        deselect = cs_s2;              // Select is high.
   wire        rise     = sck_s2 & ~sck_s3;   // Link clock rising edge.
   wire        fall     = ~sck_s2 & sck_s3;   // Link clock falling edge.
   wire [23:0] in_next  = {in_sh[22:0], sin_s2}; // Shift with new bit.
   wire        cmd_last = (cnt == `FDT_CMD_BITS - 5'h01);
   wire        adr_last = (cnt == `FDT_ADDR_BITS - 5'h01);
   wire        dum_last = (cnt == `FDT_DUMMY_BITS - 5'h01);
   wire        cmd_hit  = (in_next[7:0] == CMD_CODE);
   wire [7:0]  cur_byte = table_byte(addr); // Byte at the read address.

   // Phase sequence of one frame, advanced on link clock rising edges.
   always_comb begin
      next_state = state;
      case (state)
         FDT_D_CMD: begin
            // An unknown command leaves the rest of the frame ignored.
            if (cmd_last) begin
               next_state = cmd_hit ? FDT_D_ADDR : FDT_D_SKIP;
            end
         end
         FDT_D_ADDR: begin
            // Three address bytes whatever the array address mode.
            if (adr_last) begin
               next_state = FDT_D_DUMMY;
            end
         end
         FDT_D_DUMMY: begin
            // Output stays released through the dummy clocks.
            if (dum_last) begin
               next_state = FDT_D_DATA;
            end
         end
         FDT_D_DATA: begin
            // Data runs until deselect; no burst wrap length applies.
            next_state = FDT_D_DATA;
         end
         FDT_D_SKIP: begin
            // Waits for deselect.
            next_state = FDT_D_SKIP;
         end
         default: begin
            next_state = FDT_D_SKIP;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame sequencing.
   ////////////////////////////////////////////////////////////////////////

   // Deselect returns the device to command phase at any point.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         state <= FDT_D_CMD;
      end else if (deselect) begin
         state <= FDT_D_CMD;
      end else if (rise) begin
         state <= next_state;
      end
   end

   // Phase clock counter, cleared when the phase changes.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         cnt <= 5'h00;
      end else if (deselect || (rise && next_state != state)) begin
         cnt <= 5'h00;
      end else if (rise) begin
         cnt <= cnt + 5'h01;
      end
   end

   // Input shift register for command and address bits.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         in_sh <= 24'h000000;
      end else if (rise) begin
         in_sh <= in_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data output.
   ////////////////////////////////////////////////////////////////////////

   // Read address: loaded from the address bytes, then advanced per byte.
   // The counter is as wide as the table, so it wraps to zero by itself.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         addr <= '0;
      end else if (rise && state == FDT_D_ADDR && adr_last) begin
         addr <= in_next[`FDT_TBL_AW-1:0];
      end else if (fall && state == FDT_D_DATA && bit_cnt == 3'h0) begin
         addr <= addr + 1'b1;
      end
   end

   // Bit position within the byte being sent.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         bit_cnt <= 3'h0;
      end else if (state != FDT_D_DATA) begin
         bit_cnt <= 3'h0;
      end else if (fall) begin
         bit_cnt <= bit_cnt + 3'h1;
      end
   end

   // Bits change on falling edges so the host samples them on rising ones.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         LINK.sout <= 1'b0;
         out_sh    <= 7'h00;
      end else if (fall && state == FDT_D_DATA) begin
         if (bit_cnt == 3'h0) begin
            // First bit of a new byte, most significant first.
            LINK.sout <= cur_byte[7];
            out_sh    <= cur_byte[6:0];
         end else begin
            LINK.sout <= out_sh[6];
            out_sh    <= {out_sh[5:0], 1'b0};
         end
      end
   end

   // The line is driven from the first data bit until deselect.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         LINK.sout_oe_n <= 1'b1;
      end else if (deselect || state != FDT_D_DATA) begin
         LINK.sout_oe_n <= 1'b1;
      end else if (fall) begin
         LINK.sout_oe_n <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // User side status.
   ////////////////////////////////////////////////////////////////////////

   // Status outputs are plain flops of the frame state.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         SELECTED  <= 1'b0;
         STREAMING <= 1'b0;
      end else begin
         SELECTED  <= ~deselect;
         STREAMING <= ~LINK.sout_oe_n;
      end
   end

endmodule

// File: hdl/fdt_host.sv
// Purpose: Host end that reads the discovery table over the link.
// Assumes: Link clock made here by dividing MCLK; mode 0, MSB first.
// Notes:   Reads LEN bytes from ADDR; LEN of zero sends only the header.
`timescale 1ns/10ps
`include "fdt_consts.svh"

module fdt_host
   import fdt_pkg::*;
#(
   parameter int         HALF     = `FDT_HALF_DEF, // Half clock, MCLKs.
   parameter logic [7:0] CMD_CODE = `FDT_CMD       // Discovery command.
)(
   input  wire logic        MCLK,     // System clock.
   input  wire logic        NRST,     // Asynchronous reset, active low.
   fdt_if.host              LINK,     // Serial link to the device.
   input  wire logic        START,    // Begin a read, one-cycle pulse.
   input  wire logic [23:0] ADDR,     // First table address.
   input  wire logic [15:0] LEN,      // Number of bytes to read.
   output logic             BUSY,     // Read in progress.
   output logic [7:0]       RD_DATA,  // Last byte received.
   output logic             RD_VALID, // RD_DATA updated, one cycle.
   output logic             DONE      // Read finished, one cycle.
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations and decoding.
   ////////////////////////////////////////////////////////////////////////

   fdt_host_state_e state;   // Sequencer state.
   logic [7:0]      div;     // Half period counter.
   logic [19:0]     bitn;    // Link clocks completed.
   logic [19:0]     total;   // Link clocks in this frame.
   logic [39:0]     out_sh;  // Command, address, then dummy zeros.
   logic [7:0]      rx;      // Receive shift register.
   logic            sout_s1; // Device line, first stage.
   logic            sout_s2; // Device line, second stage.

   wire       tick    = (div == 8'(HALF - 1));          // Half period end.
   wire       up      = tick && state == FDT_H_XFER && !LINK.sck;
   wire       down    = tick && state == FDT_H_XFER && LINK.sck;
   wire       in_data = (bitn >= `FDT_HEAD_BITS);       // Data phase.
   wire [7:0] rx_next = {rx[6:0], sout_s2};             // Byte with bit.

   // The device line passes two flip-flops before it is sampled.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         sout_s1 <= 1'b0;
         sout_s2 <= 1'b0;
      end else begin
         sout_s1 <= LINK.serial_out_line;
         sout_s2 <= sout_s1;
      end
   end

   // Half period divider, restarted whenever the sequencer is idle.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         div <= 8'h00;
      end else if (state == FDT_H_IDLE || tick) begin
         div <= 8'h00;
      end else begin
         div <= div + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer.
   ////////////////////////////////////////////////////////////////////////

   // Select, clocking, bit shifting and deselect of one frame.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         state               <= FDT_H_IDLE;
         LINK.cs_n           <= 1'b1;
         LINK.sck            <= 1'b0;
         LINK.serial_in_line <= 1'b0;
         out_sh              <= 40'h0000000000;
         bitn                <= 20'h00000;
         total               <= 20'h00000;
         DONE                <= 1'b0;
      end else begin
         DONE <= 1'b0;
         case (state)
            FDT_H_IDLE: begin
               // Select and present the first command bit.
               if (START) begin
                  state               <= FDT_H_SETUP;
                  LINK.cs_n           <= 1'b0;
                  out_sh              <= {CMD_CODE[6:0], ADDR, 9'h000};
                  LINK.serial_in_line <= CMD_CODE[7];
                  bitn                <= 20'h00000;
                  total <= `FDT_HEAD_BITS + {1'b0, LEN, 3'h0};
               end
            end
            FDT_H_SETUP: begin
               // Select setup of one half period.
               if (tick) begin
                  state <= FDT_H_XFER;
               end
            end
            FDT_H_XFER: begin
               if (up) begin
                  LINK.sck <= 1'b1;
               end else if (down) begin
                  // Next bit goes out on the falling edge.
                  LINK.sck            <= 1'b0;
                  LINK.serial_in_line <= out_sh[39];
                  out_sh              <= {out_sh[38:0], 1'b0};
                  bitn                <= bitn + 20'h00001;
                  if (bitn + 20'h00001 == total) begin
                     state <= FDT_H_HOLD;
                  end
               end
            end
            FDT_H_HOLD: begin
               // Hold select one half period, then release it.
               if (tick) begin
                  state     <= FDT_H_IDLE;
                  LINK.cs_n <= 1'b1;
                  DONE      <= 1'b1;
               end
            end
            default: begin
               state <= FDT_H_IDLE;
            end
         endcase
      end
   end

   // Data bits are taken on rising edges; a byte is out every eighth.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         rx       <= 8'h00;
         RD_DATA  <= 8'h00;
         RD_VALID <= 1'b0;
      end else begin
         RD_VALID <= 1'b0;
         if (up && in_data) begin
            rx <= rx_next;
            if (bitn[2:0] == 3'h7) begin
               RD_DATA  <= rx_next;
               RD_VALID <= 1'b1;
            end
         end
      end
   end

   // Busy for the whole frame, select hold included.
   assign BUSY = (state != FDT_H_IDLE);

endmodule

// File: testbench/fdt_link_monitor.sv
// Purpose: Checks the serial link between the host and device ends.
// Assumes: One clock domain, MCLK, with NRST as its reset.
// Notes:   Link clock edges are found by sampling sck on MCLK.
`timescale 1ns/10ps
`include "fdt_consts.svh"

module fdt_link_monitor
   import fdt_pkg::*;
#(
   parameter logic [7:0] CMD = `FDT_CMD // Discovery command code.
)(
   input wire logic MCLK,            // System clock.
   input wire logic NRST,            // Asynchronous reset, active low.
   input wire logic sck,             // Link clock.
   input wire logic cs_n,            // Select, active low.
   input wire logic serial_in_line,  // Host to device data.
   input wire logic sout,            // Device output value.
   input wire logic sout_oe_n,       // Device output enable, low drives.
   input wire logic serial_out_line  // Resolved device line.
);
   logic        sck_q; // Link clock one cycle ago.
   logic [15:0] cnt;   // Link clock rises seen in this frame.
   wire         rise = sck & ~sck_q; // A link clock rise this cycle.

   ////////////////////////////////////////
   // Finds link clock rises.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) sck_q <= 1'b0;
      else sck_q <= sck;
   end

   // Counts rises while selected; a deselect clears the count.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) cnt <= 16'h0000;
      else if (cs_n) cnt <= 16'h0000;
      else if (rise) cnt <= cnt + 16'h0001;
   end

   ////////////////////////////////////////
   default clocking @(posedge MCLK); endclocking
   default disable iff (!NRST);

   a_sel_first: assert property (rise |-> !cs_n)
      else $error("link clock rose while deselected");
   a_cmd_bits: assert property (rise && cnt < 16'h0008
      |-> serial_in_line == CMD[3'h7 - cnt[2:0]])
      else $error("command bit wrong");
   a_dummy_zero: assert property (rise && cnt >= 16'h0020
      && cnt < 16'h0028 |-> !serial_in_line)
      else $error("dummy bit not zero");
   a_whole_units: assert property ($rose(cs_n) |->
      $past(cnt) >= 16'h0028 && ($past(cnt) & 16'h0007) == 16'h0000)
      else $error("frame not whole bytes");
   a_head_silent: assert property (!cs_n && cnt >= 16'h0001
      && cnt < 16'h0028 |-> sout_oe_n)
      else $error("output driven before data");
   a_data_driven: assert property (!cs_n && cnt > 16'h0028
      |-> !sout_oe_n)
      else $error("output not driven in data");
   a_bit_hold: assert property (rise && !sout_oe_n
      |=> $stable(sout) [*4])
      else $error("data bit moved while clock high");
   a_out_release: assert property ($rose(cs_n) |-> ##[1:6] sout_oe_n)
      else $error("output not released");
   a_idle_quiet: assert property (cs_n [*6] |-> sout_oe_n)
      else $error("output driven while idle");

   // Main scenarios: full header, data phase, driven line.
   c_head: cover property (rise && cnt == 16'h0027);
   c_data_end: cover property ($rose(cs_n) && $past(cnt) > 16'h0028);
   c_line_high: cover property (!sout_oe_n && serial_out_line);
endmodule

// File: testbench/flash_discovery_table_reader_tb_top.sv
// Purpose: Self-checking bench for both ends of the discovery link.
// Assumes: Link a joins host and device; link b is driven by hand.
// Notes:   The hand-made link clock has a 48 ns period.
`timescale 1ns/10ps
`include "fdt_consts.svh"

module flash_discovery_table_reader_tb_top
   import fdt_pkg::*;
;
   logic        mclk, nrst, start, busy, rd_valid, done; // Host side.
   logic        strm, st_seen, drv_b; // Device flags and sticky marks.
   logic        sel, sel_seen;        // Device select flag and its mark.
   logic [23:0] addr;    // First table address.
   logic [15:0] len;     // Byte count.
   logic [7:0]  rd_data; // Received byte.
   logic [31:0] got;     // Bits seen on link b.
   logic [7:0]  q[$];    // Bytes received by the host.
   int          err_count, n_tests;
   int          cyc = 0; // Cycles run, for the hang limit.
   // Expected bytes 00h..0Fh and 30h..3Fh, lowest address lowest.
   localparam logic [127:0] HDR = 128'hFF00003009010000FF00010050444653;
   localparam logic [127:0] BPT = 128'hBB273B276B27EB291FFFFFFFFFFB20E5;

   fdt_if link_a ();
   fdt_if link_b ();
   fdt_dev fdt_dev_inst (.MCLK(mclk), .NRST(nrst), .LINK(link_a),
      .SELECTED(sel), .STREAMING(strm));
   fdt_dev fdt_dev_inst_b (.MCLK(mclk), .NRST(nrst), .LINK(link_b),
      .SELECTED(), .STREAMING());
   fdt_host fdt_host_inst (.MCLK(mclk), .NRST(nrst), .LINK(link_a),
      .START(start), .ADDR(addr), .LEN(len), .BUSY(busy),
      .RD_DATA(rd_data), .RD_VALID(rd_valid), .DONE(done));
   fdt_link_monitor fdt_link_monitor_inst (.MCLK(mclk), .NRST(nrst),
      .sck(link_a.sck), .cs_n(link_a.cs_n),
      .serial_in_line(link_a.serial_in_line), .sout(link_a.sout),
      .sout_oe_n(link_a.sout_oe_n),
      .serial_out_line(link_a.serial_out_line));

   ////////////////////////////////////////
   // Makes the 250 MHz system clock.
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // Collects bytes and sticky marks at the falling edge, where the
   // flops launched by the rising edge have settled.
   always @(negedge mclk) begin
      if (rd_valid === 1'b1) q.push_back(rd_data);
      if (strm === 1'b1) st_seen = 1'b1;
      if (sel === 1'b1) sel_seen = 1'b1;
      if (link_b.sout_oe_n === 1'b0) drv_b = 1'b1;
   end

   // Cuts a hang short.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 32'h0000_7530) begin
         err_count++;
         $display("mismatch at %0t: timeout", $time);
         give_verdict();
      end
   end

   ////////////////////////////////////////
   // Expected table byte; unpopulated places read all ones.
   function automatic logic [7:0] exp_b(input logic [10:0] a);
      if (a[10:4] == 7'h00) return HDR[a[3:0]*8 +: 8];
      if (a[10:4] == 7'h03) return BPT[a[3:0]*8 +: 8];
      return 8'hFF;
   endfunction

   // Counts one comparison and reports a miss.
   task automatic chk(input bit ok, input string m);
      n_tests++;
      if (!ok) begin
         err_count++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic give_verdict();
      $display("checks %0d, errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Reads n bytes through the host end and checks each one.
   task automatic rd(input logic [23:0] a, input logic [15:0] n);
      int k;
      q.delete();
      @(negedge mclk);
      addr = a;
      len = n;
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      chk(busy === 1'b1, "busy not raised");
      k = 0;
      while (done !== 1'b1 && k < 32'h4E20) begin
         @(negedge mclk);
         k++;
      end
      @(negedge mclk);
      chk(busy === 1'b0 && q.size() == n, "byte count or busy");
      for (k = 0; k < n; k++) begin
         chk(q[k] === exp_b(a[10:0] + k[10:0]), "table byte");
      end
   endtask

   // Sends a header on link b by hand, then nd data clocks and a
   // deselect; the data line goes to the opposite level when idle.
   task automatic bb(input logic [39:0] hd, input int nd);
      int i;
      drv_b = 1'b0;
      link_b.cs_n = 1'b0;
      for (i = 0; i < 40 + nd; i++) begin
         link_b.serial_in_line = (i < 40) ? hd[39 - i] : 1'b0;
         repeat (6) @(negedge mclk);
         got = {got[30:0], link_b.serial_out_line};
         link_b.sck = 1'b1;
         repeat (6) @(negedge mclk);
         link_b.sck = 1'b0;
      end
      repeat (6) @(negedge mclk);
      link_b.cs_n = 1'b1;
      link_b.serial_in_line = 1'b1;
      repeat (8) @(negedge mclk);
      chk(link_b.sout_oe_n === 1'b1, "line not released");
   endtask

   ////////////////////////////////////////
   // Main sequence.
   initial begin
      nrst = 1'b0;
      start = 1'b0;
      addr = 24'h000000;
      len = 16'h0000;
      err_count = 0;
      n_tests = 0;
      got = 32'h0000_0000;
      st_seen = 1'b0;
      sel_seen = 1'b0;
      drv_b = 1'b0;
      link_b.sck = 1'b0;
      link_b.cs_n = 1'b1;
      link_b.serial_in_line = 1'b0;
      repeat (10) @(negedge mclk);
      nrst = 1'b1;
      @(negedge mclk);
      chk(sel === 1'b0, "selected while idle");
      rd(24'h000000, 16'h0040);
      chk(st_seen === 1'b1, "no streaming");
      chk(sel_seen === 1'b1, "select not seen");
      rd(24'h000030, 16'h0010);
      rd(24'h0007FE, 16'h0004);
      rd(24'h00003E, 16'h0004);
      rd(24'h000010, 16'h0000);
      bb({`FDT_CMD, 24'h0007FF, 8'h00}, 19);
      chk(got[18:0] === {8'hFF, 8'h53, 3'b010} && drv_b === 1'b1, "wire");
      bb({~`FDT_CMD, 24'h000000, 8'h00}, 16);
      chk(drv_b === 1'b0, "driven on wrong command");
      give_verdict();
   end
endmodule
